// ==== verilog/wpm_regs.vh ====
`ifndef WPM_REGS_VH
`define WPM_REGS_VH
// ==========================================
// register byte addresses (apb, one word each)
`define WPM_WT_BASE       12'h000
`define WPM_CTRL_ADDR     12'h040
`define WPM_STATUS_ADDR   12'h044
// ==========================================
// window entry fields
`define WPM_SHIFT_LSB     0
`define WPM_SHIFT_MSB     4
`define WPM_PLANES_LSB    5
`define WPM_PLANES_MSB    8
`define WPM_MODE_LSB      9
`define WPM_MODE_MSB      11
`define WPM_OLLOC_BIT     12
`define WPM_OLMASK_LSB    13
`define WPM_OLMASK_MSB    16
`define WPM_START_LSB     17
`define WPM_START_MSB     22
`define WPM_BYPASS_BIT    23
// ==========================================
// display mode codes
`define WPM_MODE_TRUE     3'b000
`define WPM_MODE_PSEUDO   3'b001
`define WPM_MODE_BANK     3'b010
`define WPM_MODE_IL_TRUE  3'b100
`define WPM_MODE_IL_PSEU  3'b101
// ==========================================
// control bits, reset values and levels
`define WPM_CTRL_PED_BIT  0
`define WPM_CTRL_SYNC_BIT 1
`define WPM_CTRL_RESET    32'h0000_0003
`define WPM_WT_RESET      24'h00_0000
`define WPM_NIB_UPPER     5'h04
`define WPM_LEVEL_WHITE   8'hff
`define WPM_LEVEL_BLACK   8'h00
`define WPM_ADDR_LIMIT    10'h20f
`endif

// ==== verilog/wpm_window_pixel_mapper.v ====
// Notes on behaviour
// RULE1 - start field forms upper palette address bits
// RULE2 - one start step moves sixteen rows
// RULE3 - software keeps start at most 100000
// RULE4 - start plus pixel stays in table
// RULE5 - maps may overlap; sizes sixteen to 512
// RULE6 - bypass sends shifted bytes straight out
// RULE7 - bypass only with eight planes
// RULE8 - bypass pseudo color gives gray scale
// RULE9 - overlays still win during bypass
// RULE10 - true color: bytes at 0, 8, 16
// RULE11 - pseudo color: same planes, up to nine
// RULE12 - bank select: overlay bits above pixel
// RULE13 - mode 100: nibble per channel, fixed
// RULE14 - mode 101: green high, red low nibble
// RULE15 - shift after blank picks first nibble
// RULE16 - three bytes presented every clock
// RULE17 - blank and sync delayed with pixels
// RULE18 - pedestal and sync encode selectable
// RULE19 - zero pedestal: black equals blank
// RULE20 - blank forces blank level, sync level
// RULE21 - shift field aligns planes to bit zero
// RULE22 - overlay mask and compaction
// RULE23 - reserved modes behave as true color
`timescale 1ns/1ns
`include "wpm_regs.vh"
module wpm_window_pixel_mapper
(
  input  wire        clock_i,       // pixel clock
  input  wire        reset_n_i,     // async active-low reset
  input  wire [11:0] paddr_i,
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [31:0] pwdata_i,
  output wire [31:0] prdata_o,
  output wire        pready_o,
  output wire        pslverr_o,
  input  wire [27:0] pixel_word_in_i, // pixel and overlay planes
  input  wire [3:0]  window_type_i,   // entry select per pixel
  input  wire        load_i,          // load strobe, same clock
  input  wire        blank_n_i,       // blanking, active low
  input  wire        sync_n_i,        // sync, active low
  output reg  [9:0]  red_addr_o,      // palette addresses
  output reg  [9:0]  green_addr_o,
  output reg  [9:0]  blue_addr_o,
  output reg  [3:0]  overlay_o,       // compacted overlay word
  output reg         lookup_bypass_o, // channel bits hold direct data
  output reg  [7:0]  red_channel_bits_o,
  output reg  [7:0]  green_channel_bits_o,
  output reg  [7:0]  blue_channel_bits_o,
  output reg         blank_level_o,   // converters at blank level
  output reg         sync_level_o,    // sync current removed
  output reg         pedestal_on_o,   // 7.5 ire pedestal added
  output reg         addr_overrun_o   // address above table limit
);

// ==========================================
// reset synchroniser
reg [1:0] rst_sync_reg;
wire      rst_n = rst_sync_reg[1];
always @(posedge clock_i or negedge reset_n_i)
begin
  if (!reset_n_i)
    rst_sync_reg <= 2'b00;
  else
    rst_sync_reg <= {rst_sync_reg[0], 1'b1};
end

// ==========================================
// apb slave: table at 0x00..0x3c, control, status
reg  [23:0] wt_mem [0:15];       // window entries
reg  [31:0] ctrl_reg;            // pedestal and sync enable
reg  [31:0] prdata_reg;
reg         overrun_seen_reg;    // sticky overrun status
wire        wr_en  = psel_i & penable_i & pwrite_i;
wire        wt_hit = (paddr_i[11:6] == 6'h00) && (paddr_i[1:0] == 2'b00);
wire        ctrl_hit = (paddr_i == `WPM_CTRL_ADDR);
wire        stat_hit = (paddr_i == `WPM_STATUS_ADDR);
wire        mapped = wt_hit | ctrl_hit | stat_hit;
assign pready_o  = 1'b1;                     // zero wait states
assign pslverr_o = psel_i & penable_i & ~mapped;
assign prdata_o  = prdata_reg;

genvar gi;
generate
  for (gi = 0; gi < 16; gi = gi + 1)
  begin : g_wt
    // each entry written only by its own word
    always @(posedge clock_i or negedge rst_n)
    begin
      if (!rst_n)
        wt_mem[gi] <= `WPM_WT_RESET;
      else if (wr_en && wt_hit && paddr_i[5:2] == gi)
        wt_mem[gi] <= pwdata_i[23:0];
    end
  end
endgenerate

// control register and read data register
always @(posedge clock_i or negedge rst_n)
begin
  if (!rst_n)
  begin
    ctrl_reg   <= `WPM_CTRL_RESET;
    prdata_reg <= 32'h0000_0000;
  end
  else
  begin
    if (wr_en && ctrl_hit)
      ctrl_reg <= {30'h0000_0000, pwdata_i[1:0]};
    // read data prepared in setup phase, valid in access phase
    if (psel_i && !penable_i && !pwrite_i)
    begin
      if (wt_hit)
        prdata_reg <= {8'h00, wt_mem[paddr_i[5:2]]};
      else if (ctrl_hit)
        prdata_reg <= ctrl_reg;
      else if (stat_hit)
        prdata_reg <= {31'h0000_0000, overrun_seen_reg};
      else
        prdata_reg <= 32'h0000_0000;
    end
  end
end

// ==========================================
// stage 1: capture pixel, entry and timing
reg [27:0] pix_reg;
reg [23:0] ent_reg;
reg        load1_reg;
reg        blank1_reg;
reg        sync1_reg;
reg        blank_prev_reg;   // blank seen on earlier pixel
always @(posedge clock_i or negedge rst_n)
begin
  if (!rst_n)
  begin
    pix_reg        <= 28'h000_0000;
    ent_reg        <= `WPM_WT_RESET;
    load1_reg      <= 1'b0;
    blank1_reg     <= 1'b0;
    sync1_reg      <= 1'b0;
    blank_prev_reg <= 1'b1;
  end
  else
  begin
    pix_reg        <= pixel_word_in_i;
    ent_reg        <= wt_mem[window_type_i];
    load1_reg      <= load_i;
    blank1_reg     <= blank_n_i;
    sync1_reg      <= sync_n_i;
    blank_prev_reg <= blank1_reg;
  end
end

// entry fields
wire [4:0] f_shift  = ent_reg[`WPM_SHIFT_MSB:`WPM_SHIFT_LSB];
wire [3:0] f_planes = ent_reg[`WPM_PLANES_MSB:`WPM_PLANES_LSB];
wire [2:0] f_mode   = ent_reg[`WPM_MODE_MSB:`WPM_MODE_LSB];
wire       f_olloc  = ent_reg[`WPM_OLLOC_BIT];
wire [3:0] f_olmask = ent_reg[`WPM_OLMASK_MSB:`WPM_OLMASK_LSB];
wire [5:0] f_start  = ent_reg[`WPM_START_MSB:`WPM_START_LSB];
wire       f_bypass = ent_reg[`WPM_BYPASS_BIT];

// ==========================================
// nibble phase for the interleave modes
reg  nib_upper_reg;      // 1 = upper nibble this load
wire line_start = blank1_reg & ~blank_prev_reg;
always @(posedge clock_i or negedge rst_n)
begin
  if (!rst_n)
    nib_upper_reg <= 1'b0;
  else if (line_start)
    // a load on the first pixel already used the first nibble [RULE15]
    nib_upper_reg <= (f_shift == `WPM_NIB_UPPER) ^ load1_reg;
  else if (load1_reg)
    nib_upper_reg <= ~nib_upper_reg;               // [RULE15]
end
// first pixel of a line uses the freshly sampled phase
wire nib_sel = line_start ? (f_shift == `WPM_NIB_UPPER) : nib_upper_reg;

// ==========================================
// mapping logic
reg  [27:0] shifted;
reg  [8:0]  pmask;
reg  [3:0]  ol_raw;
reg  [3:0]  ol_and;
reg  [3:0]  ol_pack;
reg  [2:0]  ol_cnt;
reg  [9:0]  base;
reg  [9:0]  idx_r;
reg  [9:0]  idx_g;
reg  [9:0]  idx_b;
reg  [7:0]  dir_r;
reg  [7:0]  dir_g;
reg  [7:0]  dir_b;
reg  [3:0]  nr;
reg  [3:0]  ng;
reg  [3:0]  nb;
integer     k;
always @*
begin
  shifted = pix_reg >> f_shift;                        // [RULE21]
  pmask   = (9'h001 << f_planes) - 9'h001;             // zero fill above msb
  // overlay source, then mask and compaction
  if (!f_olloc)
    ol_raw = pix_reg[27:24];                           // fixed, unshifted
  else if (f_mode == `WPM_MODE_PSEUDO)
    ol_raw = shifted[f_planes +: 4];
  else
    ol_raw = {shifted[17], shifted[0], shifted[8], shifted[16]};
  ol_and  = ol_raw & f_olmask;                         // [RULE22]
  ol_pack = 4'h0;
  ol_cnt  = 3'h0;
  for (k = 0; k < 4; k = k + 1)
  begin
    if (f_olmask[k])
    begin
      ol_pack[ol_cnt[1:0]] = ol_and[k];                // [RULE22]
      ol_cnt = ol_cnt + 3'h1;
    end
  end
  // start field lands on sixteen-row boundaries
  base = {f_start[5:0], 4'h0};                         // [RULE1] [RULE2]
  // true color byte lanes; maps may overlap freely [RULE5]
  idx_r = {2'b00, shifted[7:0] & pmask[7:0]};          // [RULE10]
  idx_g = {2'b00, shifted[15:8] & pmask[7:0]};
  idx_b = {2'b00, shifted[23:16] & pmask[7:0]};
  dir_r = shifted[7:0];
  dir_g = shifted[15:8];
  dir_b = shifted[23:16];
  nr = nib_sel ? pix_reg[7:4] : pix_reg[3:0];
  ng = nib_sel ? pix_reg[15:12] : pix_reg[11:8];
  nb = nib_sel ? pix_reg[23:20] : pix_reg[19:16];
  case (f_mode)
    `WPM_MODE_PSEUDO:
    begin
      idx_r = {1'b0, shifted[8:0] & pmask};            // [RULE11]
      idx_g = idx_r;
      idx_b = idx_r;
      dir_g = dir_r;                                   // [RULE8]
      dir_b = dir_r;
    end
    `WPM_MODE_BANK:
    begin
      // overlay bits sit above the active planes [RULE12]
      idx_r = (idx_r | ({6'h00, ol_pack} << f_planes));
      idx_g = (idx_g | ({6'h00, ol_pack} << f_planes));
      idx_b = (idx_b | ({6'h00, ol_pack} << f_planes));
    end
    `WPM_MODE_IL_TRUE:
    begin
      idx_r = {6'h00, nr};                             // [RULE13]
      idx_g = {6'h00, ng};
      idx_b = {6'h00, nb};
      dir_r = {nr, nr};
      dir_g = {ng, ng};
      dir_b = {nb, nb};
    end
    `WPM_MODE_IL_PSEU:
    begin
      idx_r = {2'b00, ng, nr};                         // [RULE14]
      idx_g = idx_r;
      idx_b = idx_r;
      dir_r = {ng, nr};
      dir_g = dir_r;
      dir_b = dir_r;
    end
    default:
    begin
      // true color, and reserved codes fall back to it [RULE23]
    end
  endcase
end

// ==========================================
// stage 2: addresses, overlay, direct data; blank/sync follow
reg blank2_reg;
reg sync2_reg;
wire [10:0] sum_r = {1'b0, base} + {1'b0, idx_r};      // [RULE1]
wire [10:0] sum_g = {1'b0, base} + {1'b0, idx_g};      // carry kept: a wrap still flags
wire [10:0] sum_b = {1'b0, base} + {1'b0, idx_b};
always @(posedge clock_i or negedge rst_n)
begin
  if (!rst_n)
  begin
    red_addr_o           <= 10'h000;
    green_addr_o         <= 10'h000;
    blue_addr_o          <= 10'h000;
    overlay_o            <= 4'h0;
    lookup_bypass_o      <= 1'b0;
    red_channel_bits_o   <= `WPM_LEVEL_BLACK;
    green_channel_bits_o <= `WPM_LEVEL_BLACK;
    blue_channel_bits_o  <= `WPM_LEVEL_BLACK;
    blank2_reg           <= 1'b0;
    sync2_reg            <= 1'b0;
    addr_overrun_o       <= 1'b0;
    overrun_seen_reg     <= 1'b0;
    blank_level_o        <= 1'b1;
    sync_level_o         <= 1'b0;
    pedestal_on_o        <= 1'b1;
  end
  else
  begin
    red_addr_o      <= sum_r[9:0];
    green_addr_o    <= sum_g[9:0];
    blue_addr_o     <= sum_b[9:0];
    // overlay still reaches its palette in bypass [RULE9]
    overlay_o       <= ol_pack;
    lookup_bypass_o <= f_bypass;                       // [RULE6]
    // blank low: data ignored, converters see black code [RULE20]
    if (!blank1_reg)
    begin
      red_channel_bits_o   <= `WPM_LEVEL_BLACK;
      green_channel_bits_o <= `WPM_LEVEL_BLACK;
      blue_channel_bits_o  <= `WPM_LEVEL_BLACK;
    end
    else
    begin
      // all three bytes every clock [RULE16] [RULE6]
      red_channel_bits_o   <= dir_r;
      green_channel_bits_o <= dir_g;
      blue_channel_bits_o  <= dir_b;
    end
    // flag only; software owns the limit [RULE3] [RULE4]
    addr_overrun_o <= (sum_r > {1'b0, `WPM_ADDR_LIMIT}) | (sum_g > {1'b0, `WPM_ADDR_LIMIT})
                      | (sum_b > {1'b0, `WPM_ADDR_LIMIT});
    if (addr_overrun_o)
      overrun_seen_reg <= 1'b1;
    else if (wr_en && stat_hit && pwdata_i[0])
      overrun_seen_reg <= 1'b0;
    blank2_reg    <= blank1_reg;                       // [RULE17]
    sync2_reg     <= sync1_reg;
    blank_level_o <= ~blank2_reg;                      // [RULE20]
    // sync level only when encoding enabled [RULE18]
    sync_level_o  <= ~sync2_reg & ctrl_reg[`WPM_CTRL_SYNC_BIT];
    // no pedestal: black equals blank [RULE18] [RULE19]
    pedestal_on_o <= ctrl_reg[`WPM_CTRL_PED_BIT] & blank2_reg;
  end
end

endmodule

// ==== tb/wpm_window_pixel_mapper_properties.sv ====
`timescale 1ns/1ns
// ==========================================
// pipeline checks seen from the top ports
module wpm_props
(
  input wire        clock_i,
  input wire        reset_n_i,
  input wire        psel_i,
  input wire        penable_i,
  input wire        pready_o,
  input wire [27:0] pixel_word_in_i,
  input wire [3:0]  window_type_i,
  input wire        load_i,
  input wire        blank_n_i,
  input wire        sync_n_i,
  input wire [9:0]  red_addr_o,
  input wire [7:0]  red_channel_bits_o,
  input wire        lookup_bypass_o,
  input wire        blank_level_o,
  input wire        sync_level_o,
  input wire        pedestal_on_o
);
  // outputs keep reset values until the pipe refills, so wait
  reg  [3:0] up_reg;
  wire       rdy = up_reg == 4'hf;
  always @(posedge clock_i or negedge reset_n_i)
    if (!reset_n_i)
      up_reg <= 4'h0;
    else if (!rdy)
      up_reg <= up_reg + 4'h1;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  // ==========================================
  // sequences and properties
  sequence s_dark;
    (rdy && !blank_n_i) [*6];
  endsequence
  // a load may toggle the nibble late, hence six quiet cycles
  sequence s_quiet;
    (rdy && !psel_i && !load_i && $stable(pixel_word_in_i) && $stable(window_type_i)
      && $stable(blank_n_i)) [*6];
  endsequence
  property p_blank;
    rdy && !blank_n_i |-> ##3 blank_level_o;
  endproperty
  a_blank: assert property (p_blank) else $error("blank level late");
  property p_show;
    rdy && blank_n_i |-> ##3 !blank_level_o;
  endproperty
  a_show: assert property (p_show) else $error("blank level stuck");
  property p_nosync;
    rdy && sync_n_i |-> ##3 !sync_level_o;
  endproperty
  a_nosync: assert property (p_nosync) else $error("sync level wrong");
  property p_ped;
    rdy && blank_level_o |-> !pedestal_on_o;
  endproperty
  a_ped: assert property (p_ped) else $error("pedestal in blank");
  property p_dark;
    s_dark |-> red_channel_bits_o == 8'h00;
  endproperty
  a_dark: assert property (p_dark) else $error("data in blank");
  property p_hold;
    s_quiet |-> $stable(red_addr_o);
  endproperty
  a_hold: assert property (p_hold) else $error("address moved");
  property p_byp;
    s_quiet |-> $stable(lookup_bypass_o);
  endproperty
  a_byp: assert property (p_byp) else $error("bypass moved");
  property p_ack;
    psel_i && penable_i |-> pready_o;
  endproperty
  a_ack: assert property (p_ack) else $error("no ready");
endmodule
bind wpm_window_pixel_mapper wpm_props chk_u (.clock_i, .reset_n_i, .psel_i, .penable_i,
  .pready_o, .pixel_word_in_i, .window_type_i, .load_i, .blank_n_i, .sync_n_i, .red_addr_o,
  .red_channel_bits_o, .lookup_bypass_o, .blank_level_o, .sync_level_o, .pedestal_on_o);

// ==== tb/wpm_pixel_source.sv ====
`timescale 1ns/1ns
// ==========================================
// frame buffer side: one registered word per clock
module wpm_pixel_source
(
  input  wire        clock_i,
  input  wire [27:0] word_i,
  input  wire [3:0]  type_i,
  input  wire [1:0]  bs_i,            // blank_n, sync_n
  input  wire        load_i,
  output reg  [27:0] pixel_word_o = 28'h000_0000,
  output reg  [3:0]  type_o = 4'h0,
  output reg  [1:0]  bs_o = 2'b11,
  output reg         load_o = 1'b0
);
  // launch just after the edge, as real timing logic does
  always @(posedge clock_i)
  begin
    pixel_word_o <= word_i;
    type_o <= type_i;
    bs_o <= bs_i;
    load_o <= load_i;
  end
endmodule

// ==== tb/wpm_window_pixel_mapper_tb.sv ====
`timescale 1ns/1ns
`include "wpm_regs.vh"
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin n_mismatch++; \
  $display("Error t=%0t got %h exp %h", $time, (a), (e)); end end
module wpm_window_pixel_mapper_tb;
  reg         clock_i = 1'b0;
  reg         reset_n_i = 1'b0;
  reg         psel = 1'b0;
  reg         penable = 1'b0;
  reg         pwrite = 1'b0;
  reg  [11:0] paddr = 12'h000;
  reg  [31:0] pwdata = 32'h0000_0000;
  reg  [27:0] wd = 28'h000_0000;
  reg  [3:0]  wt = 4'h0;
  reg  [1:0]  bs = 2'b11;
  reg         ld = 1'b0;
  reg  [31:0] rd;
  reg         er;
  wire [31:0] prdata;
  wire        pready, pslverr, pl, byp, blv, syl, ped, ovr;
  wire [27:0] pw;
  wire [3:0]  pt, ov;
  wire [1:0]  pbs;
  wire [9:0]  ra, ga, ba;
  wire [7:0]  rc, gc, bc;
  integer     n_mismatch = 0;
  integer     num_checks = 0;
  integer     m;
  localparam [27:0] PX = 28'h007_a53c;
  wpm_pixel_source src_u (.clock_i(clock_i), .word_i(wd), .type_i(wt), .bs_i(bs),
    .load_i(ld), .pixel_word_o(pw), .type_o(pt), .bs_o(pbs), .load_o(pl));
  wpm_window_pixel_mapper dut_u (.clock_i(clock_i), .reset_n_i(reset_n_i), .paddr_i(paddr),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .pixel_word_in_i(pw),
    .window_type_i(pt), .load_i(pl), .blank_n_i(pbs[1]), .sync_n_i(pbs[0]),
    .red_addr_o(ra), .green_addr_o(ga), .blue_addr_o(ba), .overlay_o(ov),
    .lookup_bypass_o(byp), .red_channel_bits_o(rc), .green_channel_bits_o(gc),
    .blue_channel_bits_o(bc), .blank_level_o(blv), .sync_level_o(syl),
    .pedestal_on_o(ped), .addr_overrun_o(ovr));
  initial
    forever #5 clock_i = ~clock_i;
  function [31:0] ent(input b, input [5:0] s, input [3:0] k, input [2:0] md,
    input [3:0] n, input [4:0] sh);
    ent = {8'h00, b, s, k, 1'b0, md, n, sh};
  endfunction
  // ==========================================
  // apb master: hold the request until pready is seen
  task apb(input w, input [11:0] a, input [31:0] d);
  begin
    @(posedge clock_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_i);
    penable <= 1'b1;
    @(posedge clock_i);
    while (pready !== 1'b1)
      @(posedge clock_i);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  end
  endtask
  // hold a pixel long enough for the whole pipe to settle
  task put(input [27:0] w, input [3:0] t, input [1:0] b, input l);
  begin
    @(posedge clock_i);
    wd <= w;
    wt <= t;
    bs <= b;
    ld <= l;
    @(posedge clock_i);
    ld <= 1'b0;
    repeat (6)
      @(posedge clock_i);
    #1;
  end
  endtask
  task results;
  begin
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  end
  endtask
  initial
  begin
    #60000;
    n_mismatch++;
    results;
  end
  // ==========================================
  // tests
  initial
  begin
    repeat (4)
      @(posedge clock_i);
    reset_n_i <= 1'b1;
    repeat (3)
      @(posedge clock_i);
    apb(1'b0, `WPM_CTRL_ADDR, 32'h0000_0000);
    `CHK(rd, `WPM_CTRL_RESET)
    apb(1'b0, `WPM_WT_BASE, 32'h0000_0000);
    `CHK(rd[23:0], `WPM_WT_RESET)
    apb(1'b0, 12'h048, 32'h0000_0000);
    `CHK({er, rd}, 33'h1_0000_0000)
    $display("test 1 done");
    apb(1'b1, 12'h000, ent(0, 6'h01, 4'h0, 3'b000, 4'h8, 5'h00));
    apb(1'b1, 12'h004, ent(0, 6'h20, 4'h0, 3'b000, 4'h8, 5'h00));
    apb(1'b0, 12'h004, 32'h0000_0000);
    `CHK(rd[23:0], 24'h40_0100)
    put(28'h003_0201, 4'h0, 2'b11, 1'b0);
    `CHK({ra, ga, ba}, {10'h011, 10'h012, 10'h013})
    put(28'h000_0f00, 4'h1, 2'b11, 1'b0);
    `CHK({ra, ga, ba, ovr}, {10'h200, 10'h20f, 10'h200, 1'b0})
    apb(1'b1, 12'h008, ent(0, 6'h02, 4'h0, 3'b001, 4'h9, 5'h04));
    put(28'h001_2340, 4'h2, 2'b11, 1'b0);
    `CHK({ra, ga, ba}, {10'h054, 10'h054, 10'h054})
    apb(1'b1, 12'h00c, ent(0, 6'h20, 4'h0, 3'b001, 4'h9, 5'h00));
    put(28'h000_01ff, 4'h3, 2'b11, 1'b0);
    `CHK({ra, ovr}, {10'h3ff, 1'b1})
    apb(1'b0, `WPM_STATUS_ADDR, 32'h0000_0000);
    `CHK(rd, 32'h0000_0001)
    apb(1'b1, 12'h010, ent(0, 6'h00, 4'ha, 3'b010, 4'h4, 5'h00));
    put(28'he00_0003, 4'h4, 2'b11, 1'b0);
    `CHK({ov, ra, ba}, {4'h3, 10'h033, 10'h030})
    apb(1'b1, `WPM_STATUS_ADDR, 32'h0000_0001);
    apb(1'b0, `WPM_STATUS_ADDR, 32'h0000_0000);
    `CHK(rd, 32'h0000_0000)
    $display("test 2 done");
    apb(1'b1, 12'h014, ent(1, 6'h00, 4'hf, 3'b000, 4'h8, 5'h04));
    apb(1'b1, 12'h018, ent(1, 6'h00, 4'h0, 3'b001, 4'h8, 5'h04));
    put(28'habc_def0, 4'h5, 2'b11, 1'b0);
    `CHK({byp, ov, rc, gc, bc}, {1'b1, 4'ha, 24'hef_cdab})
    put(28'habc_def0, 4'h6, 2'b11, 1'b0);
    `CHK({rc, gc, bc}, 24'hef_efef)
    $display("test 3 done");
    apb(1'b1, 12'h01c, ent(0, 6'h00, 4'h0, 3'b101, 4'h8, 5'h04));
    apb(1'b1, 12'h020, ent(0, 6'h00, 4'h0, 3'b101, 4'h8, 5'h00));
    apb(1'b1, 12'h024, ent(0, 6'h00, 4'h0, 3'b100, 4'h8, 5'h00));
    put(PX, 4'h7, 2'b01, 1'b0);
    put(PX, 4'h7, 2'b11, 1'b0);
    `CHK({ra, ga, ba}, {10'h0a3, 10'h0a3, 10'h0a3})
    put(PX, 4'h7, 2'b11, 1'b1);
    `CHK({ra, ga, ba}, {10'h05c, 10'h05c, 10'h05c})
    put(PX, 4'h8, 2'b01, 1'b1);
    put(PX, 4'h8, 2'b11, 1'b0);
    `CHK(ra, 10'h05c)
    put(PX, 4'h9, 2'b01, 1'b0);
    put(PX, 4'h9, 2'b11, 1'b0);
    `CHK({ra, ga, ba}, {10'h00c, 10'h005, 10'h007})
    $display("test 4 done");
    put(PX, 4'h0, 2'b00, 1'b0);
    `CHK({blv, syl, ped, rc, gc, bc}, {3'b110, 24'h00_0000})
    put(PX, 4'h0, 2'b10, 1'b0);
    `CHK({blv, syl, ped}, 3'b011)
    apb(1'b1, `WPM_CTRL_ADDR, 32'h0000_0000);
    put(PX, 4'h0, 2'b11, 1'b0);
    `CHK({blv, syl, ped}, 3'b000)
    put(PX, 4'h0, 2'b00, 1'b0);
    `CHK({blv, syl, ped}, 3'b100)
    $display("test 5 done");
    for (m = 3; m < 8; m = (m == 3) ? 6 : m + 1)
    begin
      apb(1'b1, 12'h028, ent(0, 6'h01, 4'h0, m[2:0], 4'h8, 5'h00));
      put(28'h003_0201, 4'ha, 2'b11, 1'b0);
      `CHK({ra, ga, ba}, {10'h011, 10'h012, 10'h013})
    end
    $display("test 6 done");
    results;
  end
endmodule
